// *** include/pcx_defines.vh ***
`ifndef PCX_DEFINES_VH
`define PCX_DEFINES_VH

// Register bus offsets (word index)
`define PCX_REG_CTRL 4'h0
`define PCX_REG_OPND 4'h1
`define PCX_REG_PC 4'h2
`define PCX_REG_FRAME 4'h3
`define PCX_REG_STACK 4'h4
`define PCX_REG_CSW 4'h5
`define PCX_REG_STAT 4'h6

// Control register bits
`define PCX_CTRL_CALL 0
`define PCX_CTRL_EXIT 1

// Status register bits
`define PCX_STAT_DONE 0
`define PCX_STAT_ILL 1
`define PCX_STAT_OVF 2
`define PCX_STAT_BUSY 3

// Context status word bit positions (bit 15 is the leftmost bit)
`define PCX_CSW_LIB 11
`define PCX_CSW_CODE 10
`define PCX_CSW_DATA 9
`define PCX_CSW_SUP 8
`define PCX_CSW_TRAP 7
`define PCX_CSW_CARRY 6
`define PCX_CSW_OVFL 5
`define PCX_CSW_NEG 4
`define PCX_CSW_ZERO 3
`define PCX_CSW_RP_HI 2
`define PCX_CSW_RP_LO 0

// Values
`define PCX_RP_EMPTY 3'h7
`define PCX_CSW_RST 16'h0007
`define PCX_STACK_LIMIT 17'h07FFF
`define PCX_MARKER_LEN 17'h00003
`define PCX_BOUND_CALLABLE 16'h0000
`define PCX_BOUND_SUPERVISOR_STATE_BIT 16'h0001

`endif

// *** rtl/pcx_class_check.v ***
`timescale 1ns/1ps
// Unsigned compare of the entry index against a boundary word
module pcx_class_check #(
	parameter W = 16
) (
	input wire [W-1:0] entry_idx, // Index field of the call
	input wire [W-1:0] bound, // Boundary word read from code memory
	output wire at_or_above // Index is equal to or above the boundary
);
	assign at_or_above = (entry_idx >= bound);
endmodule

// *** rtl/pcx_env_merge.v ***
`timescale 1ns/1ps
`include "pcx_defines.vh"
// Status word rebuilt on return from current and saved copies
module pcx_env_merge (
	input wire [15:0] cur_csw, // Status word now in force
	input wire [15:0] saved_csw, // Status word saved in the stack marker
	output reg [15:0] merged_csw // Status word to take on return
);
	always @* begin
		merged_csw = cur_csw;
		merged_csw[`PCX_CSW_SUP] = cur_csw[`PCX_CSW_SUP] & saved_csw[`PCX_CSW_SUP];
		merged_csw[`PCX_CSW_DATA] = cur_csw[`PCX_CSW_DATA] & saved_csw[`PCX_CSW_DATA];
		merged_csw[`PCX_CSW_CODE] = saved_csw[`PCX_CSW_CODE];
		merged_csw[`PCX_CSW_LIB] = saved_csw[`PCX_CSW_LIB];
		merged_csw[`PCX_CSW_TRAP] = saved_csw[`PCX_CSW_TRAP];
		merged_csw[`PCX_CSW_OVFL] = saved_csw[`PCX_CSW_OVFL];
		merged_csw[`PCX_CSW_CARRY] = saved_csw[`PCX_CSW_CARRY];
		// condition code and stack index kept; positions
		merged_csw[`PCX_CSW_NEG] = cur_csw[`PCX_CSW_NEG];
		merged_csw[`PCX_CSW_ZERO] = cur_csw[`PCX_CSW_ZERO];
		merged_csw[`PCX_CSW_RP_HI:`PCX_CSW_RP_LO] = cur_csw[`PCX_CSW_RP_HI:`PCX_CSW_RP_LO];
	end
endmodule

// *** rtl/pcx_unit.v ***
// Behaviour
// - Call writes return address, status word, frame base at stack top +1,+2,+3.
// - Privilege-class check runs only for callers outside supervisor state.
// - Index at or above code word zero means callable or privileged callee.
// - Index at or above code word one aborts to illegal-call trap.
// - Index between the two boundaries sets the supervisor bit.
// - Frame base and stack top both become old stack top plus three.
// - New stack top above 32767 unsigned aborts to stack overflow trap.
// - Entry table word at the index becomes the next program counter.
// - Call ends by setting operand stack index to 7, stack empty.
// - Return first sets stack top to frame base minus decrement field.
// - Return loads program counter from frame base minus two.
// - Return takes lesser of saved and current privilege and data bits.
// - Return restores code, library, trap, overflow, carry bits from frame base minus one.
// - Return keeps condition code and operand stack index unchanged.
// - Return finally reloads frame base from memory at frame base.
// - Operand stack index is the three low bits of the status word.
// - Condition code: negative bit at 11, zero bit at 12.
// - Carry at status position 9, overflow at position 10.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pcx_defines.vh"
module pcx_unit #(
	parameter AW = 4
) (
	input wire core_clk, // Processor clock
	input wire rst_n, // Asynchronous reset, active low
	input wire [AW-1:0] bus_addr, // Register word index
	input wire [15:0] bus_wdata, // Register write data
	input wire bus_wr, // Write strobe
	input wire bus_rd, // Read strobe
	output reg [15:0] bus_rdata_r, // Read data, cycle after the strobe
	output reg mem_req_r, // Memory request, held until acknowledged
	output reg mem_we_r, // Memory request is a write
	output reg mem_code_r, // Memory request targets code space
	output reg [15:0] mem_addr_r, // Memory word address
	output reg [15:0] mem_wdata_r, // Memory write data
	input wire [15:0] mem_rdata, // Memory read data, valid with acknowledge
	input wire mem_ack, // One-cycle acknowledge from memory
	output reg busy_r, // Sequence in progress
	output reg done_r, // One-cycle pulse on successful completion
	output reg trap_illegal_r, // One-cycle pulse: illegal-call trap
	output reg trap_overflow_r // One-cycle pulse: stack overflow trap
);
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_CW1 = 4'h1;
	localparam [3:0] ST_CW2 = 4'h2;
	localparam [3:0] ST_CW3 = 4'h3;
	localparam [3:0] ST_CC0 = 4'h4;
	localparam [3:0] ST_CC1 = 4'h5;
	localparam [3:0] ST_CPTR = 4'h6;
	localparam [3:0] ST_COVF = 4'h7;
	localparam [3:0] ST_CENT = 4'h8;
	localparam [3:0] ST_CRP = 4'h9;
	localparam [3:0] ST_XS = 4'hA;
	localparam [3:0] ST_XP = 4'hB;
	localparam [3:0] ST_XE = 4'hC;
	localparam [3:0] ST_XL = 4'hD;

	reg [3:0] state_r, state_nxt;
	reg [15:0] pc_r, pc_nxt;
	reg [15:0] frame_r, frame_nxt;
	reg [15:0] stack_r, stack_nxt;
	reg [15:0] csw_r, csw_nxt;
	reg [15:0] opnd_r, opnd_nxt;
	reg [16:0] stack_new_r, stack_new_nxt;
	reg sup_pend_r, sup_pend_nxt;
	reg st_done_r, st_done_nxt;
	reg st_ill_r, st_ill_nxt;
	reg st_ovf_r, st_ovf_nxt;
	reg [15:0] bus_rdata_nxt;
	reg mem_req_nxt, mem_we_nxt, mem_code_nxt;
	reg [15:0] mem_addr_nxt, mem_wdata_nxt;
	reg done_nxt, trap_ill_nxt, trap_ovf_nxt;
	wire at_or_above;
	wire [15:0] merged_csw;

	// Memory request belongs to states that wait on an acknowledge
	function is_mem_state;
		input [3:0] st;
		begin
			case (st)
				ST_CW1, ST_CW2, ST_CW3, ST_CC0, ST_CC1, ST_CENT, ST_XP, ST_XE, ST_XL:
					is_mem_state = 1'b1;
				default:
					is_mem_state = 1'b0;
			endcase
		end
	endfunction

	// boundary compare on the word just read
	pcx_class_check #(.W(16)) u_class (
		.entry_idx(opnd_r),
		.bound(mem_rdata),
		.at_or_above(at_or_above)
	);

	pcx_env_merge u_merge (
		.cur_csw(csw_r),
		.saved_csw(mem_rdata),
		.merged_csw(merged_csw)
	);

	// Sequencer and register file
	always @* begin
		state_nxt = state_r;
		pc_nxt = pc_r;
		frame_nxt = frame_r;
		stack_nxt = stack_r;
		csw_nxt = csw_r;
		opnd_nxt = opnd_r;
		stack_new_nxt = stack_new_r;
		sup_pend_nxt = sup_pend_r;
		st_done_nxt = st_done_r;
		st_ill_nxt = st_ill_r;
		st_ovf_nxt = st_ovf_r;
		done_nxt = 1'b0;
		trap_ill_nxt = 1'b0;
		trap_ovf_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				// Software may load the context only while idle
				if (bus_wr) begin
					case (bus_addr)
						`PCX_REG_OPND: opnd_nxt = bus_wdata;
						`PCX_REG_PC: pc_nxt = bus_wdata;
						`PCX_REG_FRAME: frame_nxt = bus_wdata;
						`PCX_REG_STACK: stack_nxt = bus_wdata;
						`PCX_REG_CSW: csw_nxt = bus_wdata;
						`PCX_REG_CTRL: begin
							if (bus_wdata[`PCX_CTRL_CALL] || bus_wdata[`PCX_CTRL_EXIT]) begin
								st_done_nxt = 1'b0;
								st_ill_nxt = 1'b0;
								st_ovf_nxt = 1'b0;
								sup_pend_nxt = 1'b0;
							end
							// Call wins if both bits are written together
							if (bus_wdata[`PCX_CTRL_CALL])
								state_nxt = ST_CW1;
							else if (bus_wdata[`PCX_CTRL_EXIT])
								state_nxt = ST_XS;
						end
						default: ;
					endcase
				end
			end
			ST_CW1: if (mem_ack) state_nxt = ST_CW2;
			ST_CW2: if (mem_ack) state_nxt = ST_CW3;
			ST_CW3: begin
				if (mem_ack) begin
					// supervisor callers skip the class check
					if (csw_r[`PCX_CSW_SUP])
						state_nxt = ST_CPTR;
					else
						state_nxt = ST_CC0;
				end
			end
			ST_CC0: begin
				if (mem_ack) begin
					// below the callable boundary: no change
					if (at_or_above)
						state_nxt = ST_CC1;
					else
						state_nxt = ST_CPTR;
				end
			end
			ST_CC1: begin
				if (mem_ack) begin
					if (at_or_above) begin
						trap_ill_nxt = 1'b1;
						st_ill_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end else begin
						// callable: supervisor bit, held until the call commits
						sup_pend_nxt = 1'b1;
						state_nxt = ST_CPTR;
					end
				end
			end
			ST_CPTR: begin
				// new pointer kept aside until the overflow check passes
				stack_new_nxt = {1'b0, stack_r} + `PCX_MARKER_LEN;
				state_nxt = ST_COVF;
			end
			ST_COVF: begin
				if (stack_new_r > `PCX_STACK_LIMIT) begin
					trap_ovf_nxt = 1'b1;
					st_ovf_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end else begin
					state_nxt = ST_CENT;
				end
			end
			ST_CENT: begin
				if (mem_ack) begin
					// entry address; frame and stack commit here
					pc_nxt = mem_rdata;
					frame_nxt = stack_new_r[15:0];
					stack_nxt = stack_new_r[15:0];
					if (sup_pend_r)
						csw_nxt[`PCX_CSW_SUP] = 1'b1;
					state_nxt = ST_CRP;
				end
			end
			ST_CRP: begin
				csw_nxt[`PCX_CSW_RP_HI:`PCX_CSW_RP_LO] = `PCX_RP_EMPTY;
				done_nxt = 1'b1;
				st_done_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
			ST_XS: begin
				stack_nxt = frame_r - opnd_r;
				state_nxt = ST_XP;
			end
			ST_XP: begin
				if (mem_ack) begin
					pc_nxt = mem_rdata;
					state_nxt = ST_XE;
				end
			end
			ST_XE: begin
				if (mem_ack) begin
					csw_nxt = merged_csw;
					state_nxt = ST_XL;
				end
			end
			ST_XL: begin
				if (mem_ack) begin
					frame_nxt = mem_rdata;
					done_nxt = 1'b1;
					st_done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Memory port follows the next state; a request drops for a cycle after each acknowledge
	always @* begin
		mem_req_nxt = is_mem_state(state_nxt) && !mem_ack;
		mem_we_nxt = 1'b0;
		mem_code_nxt = 1'b0;
		mem_addr_nxt = 16'h0000;
		mem_wdata_nxt = 16'h0000;
		case (state_nxt)
			ST_CW1: begin
				mem_we_nxt = 1'b1;
				mem_addr_nxt = stack_r + 16'h0001;
				mem_wdata_nxt = pc_r;
			end
			ST_CW2: begin
				mem_we_nxt = 1'b1;
				mem_addr_nxt = stack_r + 16'h0002;
				mem_wdata_nxt = csw_r;
			end
			ST_CW3: begin
				mem_we_nxt = 1'b1;
				mem_addr_nxt = stack_r + 16'h0003;
				mem_wdata_nxt = frame_r;
			end
			ST_CC0: begin
				mem_code_nxt = 1'b1;
				mem_addr_nxt = `PCX_BOUND_CALLABLE;
			end
			ST_CC1: begin
				mem_code_nxt = 1'b1;
				mem_addr_nxt = `PCX_BOUND_SUPERVISOR_STATE_BIT;
			end
			ST_CENT: begin
				mem_code_nxt = 1'b1;
				mem_addr_nxt = opnd_r;
			end
			ST_XP: mem_addr_nxt = frame_r - 16'h0002;
			ST_XE: mem_addr_nxt = frame_r - 16'h0001;
			ST_XL: mem_addr_nxt = frame_r;
			default: ;
		endcase
	end

	// Read data stand for one cycle only, zero otherwise
	always @* begin
		bus_rdata_nxt = 16'h0000;
		if (bus_rd) begin
			case (bus_addr)
				`PCX_REG_OPND: bus_rdata_nxt = opnd_r;
				`PCX_REG_PC: bus_rdata_nxt = pc_r;
				`PCX_REG_FRAME: bus_rdata_nxt = frame_r;
				`PCX_REG_STACK: bus_rdata_nxt = stack_r;
				`PCX_REG_CSW: bus_rdata_nxt = csw_r;
				`PCX_REG_STAT: begin
					bus_rdata_nxt[`PCX_STAT_DONE] = st_done_r;
					bus_rdata_nxt[`PCX_STAT_ILL] = st_ill_r;
					bus_rdata_nxt[`PCX_STAT_OVF] = st_ovf_r;
					bus_rdata_nxt[`PCX_STAT_BUSY] = (state_r != ST_IDLE);
				end
				default: bus_rdata_nxt = 16'h0000;
			endcase
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			pc_r <= 16'h0000;
			frame_r <= 16'h0000;
			stack_r <= 16'h0000;
			csw_r <= `PCX_CSW_RST;
			opnd_r <= 16'h0000;
			stack_new_r <= 17'h00000;
			sup_pend_r <= 1'b0;
			st_done_r <= 1'b0;
			st_ill_r <= 1'b0;
			st_ovf_r <= 1'b0;
			bus_rdata_r <= 16'h0000;
			mem_req_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_code_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			trap_illegal_r <= 1'b0;
			trap_overflow_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			frame_r <= frame_nxt;
			stack_r <= stack_nxt;
			csw_r <= csw_nxt;
			opnd_r <= opnd_nxt;
			stack_new_r <= stack_new_nxt;
			sup_pend_r <= sup_pend_nxt;
			st_done_r <= st_done_nxt;
			st_ill_r <= st_ill_nxt;
			st_ovf_r <= st_ovf_nxt;
			bus_rdata_r <= bus_rdata_nxt;
			mem_req_r <= mem_req_nxt;
			mem_we_r <= mem_we_nxt;
			mem_code_r <= mem_code_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			busy_r <= (state_nxt != ST_IDLE);
			done_r <= done_nxt;
			trap_illegal_r <= trap_ill_nxt;
			trap_overflow_r <= trap_ovf_nxt;
		end
	end
endmodule

// *** bench/pcx_mem_model.sv ***
`timescale 1ns/1ps
module pcx_mem_model (
	input wire core_clk, // Clock
	input wire rst_n, // Reset
	input wire mem_req_r, // Request
	input wire mem_we_r, // Write
	input wire mem_code_r, // Code space
	input wire [15:0] mem_addr_r, // Address
	input wire [15:0] mem_wdata_r, // Write data
	output logic mem_ack, // Acknowledge
	output logic [15:0] mem_rdata // Read data
);
	logic [15:0] data [256];
	logic [15:0] code [256];
	logic [1:0] w;
	initial begin
		code[0] = 16'h0004;
		code[1] = 16'h0008;
		for (int i = 2; i < 256; i++)
			code[i] = 16'h0100 + 16'(i);
	end
	// Latency follows the low address bits, so prompt and slow answers both occur
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0000;
			w <= 2'h0;
		end else if (mem_req_r && !mem_ack && w >= mem_addr_r[1:0]) begin
			mem_ack <= 1'b1;
			w <= 2'h0;
			if (mem_we_r)
				data[mem_addr_r[7:0]] <= mem_wdata_r;
			mem_rdata <= mem_code_r ? code[mem_addr_r[7:0]] : data[mem_addr_r[7:0]];
		end else begin
			mem_ack <= 1'b0;
			// Stale data is inverted every cycle without an acknowledge, so it is back on the bus every other cycle
			mem_rdata <= ~mem_rdata;
			if (mem_req_r && !mem_ack)
				w <= w + 2'h1;
		end
	end
endmodule

// *** bench/pcx_unit_checker.sv ***
`timescale 1ns/1ps
module pcx_unit_checker #(
	parameter AW = 4
) (
	input wire core_clk, // Clock
	input wire rst_n, // Reset
	input wire [AW-1:0] bus_addr, // Register index
	input wire [15:0] bus_wdata, // Write data
	input wire bus_wr, // Write strobe
	input wire mem_req_r, // Memory request
	input wire mem_we_r, // Write request
	input wire mem_code_r, // Code space
	input wire [15:0] mem_addr_r, // Memory address
	input wire [15:0] mem_rdata, // Memory read data
	input wire mem_ack, // Memory acknowledge
	input wire busy_r, // Busy
	input wire done_r, // Done pulse
	input wire trap_illegal_r, // Illegal trap
	input wire trap_overflow_r // Overflow trap
);
	logic [15:0] opnd_sh;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Writes while busy are dropped by the design, so the shadow drops them too
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			opnd_sh <= 16'h0000;
		else if (bus_wr && bus_addr == 4'h1 && !busy_r)
			opnd_sh <= bus_wdata;
	end
	sequence s_call_go;
		bus_wr && bus_addr == 4'h0 && bus_wdata[0] && !busy_r;
	endsequence
	sequence s_wr_next;
		mem_ack && mem_we_r ##2 mem_req_r && mem_we_r;
	endsequence
	sequence s_rd_next;
		mem_ack && !mem_we_r && !mem_code_r ##2 mem_req_r && !mem_we_r && !mem_code_r;
	endsequence
	sequence s_below_c0;
		mem_ack && mem_code_r && mem_addr_r == 16'h0000 && opnd_sh < mem_rdata;
	endsequence
	AST_MARK_WR: assert property (
		s_call_go |=> mem_req_r && mem_we_r && !mem_code_r)
		else $error("call does not open with a data write");
	AST_MARK_SEQ: assert property (
		s_wr_next |-> mem_addr_r == $past(mem_addr_r, 2) + 16'h0001)
		else $error("marker words not at consecutive addresses");
	AST_GAP: assert property (mem_ack |=> !mem_req_r)
		else $error("request not dropped after acknowledge");
	AST_RET_SEQ: assert property (
		s_rd_next |-> mem_addr_r == $past(mem_addr_r, 2) + 16'h0001)
		else $error("return reads not at consecutive addresses");
	AST_NO_BOTH: assert property (
		done_r |-> !trap_illegal_r && !trap_overflow_r)
		else $error("done together with a trap");
	AST_ILL_C1: assert property (
		trap_illegal_r |->
		$past(mem_ack) && $past(mem_code_r) && $past(mem_addr_r) == 16'h0001)
		else $error("illegal trap not after second boundary read");
	AST_OVF_TIME: assert property (
		trap_overflow_r |-> $past(mem_ack, 3) && !$past(mem_req_r))
		else $error("overflow trap at wrong time");
	AST_SKIP_C1: assert property (
		s_below_c0 |->
		##3 (trap_overflow_r || mem_req_r && mem_code_r && mem_addr_r == opnd_sh))
		else $error("index below first boundary not fetched directly");
endmodule
bind pcx_unit pcx_unit_checker #(.AW(AW)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .mem_req_r(mem_req_r),
	.mem_we_r(mem_we_r), .mem_code_r(mem_code_r), .mem_addr_r(mem_addr_r),
	.mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy_r(busy_r), .done_r(done_r),
	.trap_illegal_r(trap_illegal_r), .trap_overflow_r(trap_overflow_r));

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] C0 = 16'h0004;
	localparam logic [15:0] C1 = 16'h0008;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [3:0] bus_addr = 4'h0;
	logic [15:0] bus_wdata = 16'h0000;
	wire [15:0] bus_rdata_r, mem_addr_r, mem_wdata_r, mem_rdata;
	wire mem_req_r, mem_we_r, mem_code_r, mem_ack, busy_r, done_r, trap_illegal_r, trap_overflow_r;
	int err_count = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h11E6;
	logic [15:0] cp, cl, cs, cc, x;
	logic [2:0] ev;
	// Per case: caller supervisor bit and entry index nibble
	logic [7:0] t_sup = 8'h61;
	logic [31:0] t_idx = 32'h9338742A;
	always #5 core_clk = ~core_clk;
	pcx_unit DUT (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .mem_req_r(mem_req_r),
		.mem_we_r(mem_we_r), .mem_code_r(mem_code_r), .mem_addr_r(mem_addr_r),
		.mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy_r(busy_r),
		.done_r(done_r), .trap_illegal_r(trap_illegal_r), .trap_overflow_r(trap_overflow_r));
	pcx_mem_model M (.core_clk(core_clk), .rst_n(rst_n), .mem_req_r(mem_req_r),
		.mem_we_r(mem_we_r), .mem_code_r(mem_code_r), .mem_addr_r(mem_addr_r),
		.mem_wdata_r(mem_wdata_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	function automatic [31:0] lfsr(input [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic rnd(output [15:0] r);
		seed = lfsr(seed);
		r = seed[15:0];
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input [15:0] got, input [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [3:0] a, input [15:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rdc(input [3:0] a, input [15:0] e);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1;
		chk(bus_rdata_r, e);
	endtask
	// Outcome pulses last one cycle, so every cycle is looked at
	task automatic waitend;
		ev = 3'h0;
		for (int i = 0; i < 300 && ev == 3'h0; i++) begin
			@(posedge core_clk);
			#1;
			ev = {trap_overflow_r, trap_illegal_r, done_r};
		end
		if (ev === 3'h0) begin
			err_count++;
			summarize;
		end
	endtask
	task automatic ret(input [15:0] rp, input [15:0] sw, input [15:0] rl);
		logic [15:0] dec, ew;
		rnd(x);
		dec = 16'h0003 + {13'h0000, x[2:0]};
		rnd(cc);
		wr(4'h5, cc);
		wr(4'h1, dec);
		wr(4'h0, 16'h0002);
		waitend;
		ew = {cc[15:12], sw[11:10], cc[9:8] & sw[9:8], sw[7:5], cc[4:0]};
		chk({13'h0000, ev}, 16'h0001);
		rdc(4'h4, cl - dec);
		rdc(4'h2, rp);
		rdc(4'h5, ew);
		rdc(4'h3, rl);
	endtask
	task automatic call(input logic sup, input [15:0] idx, input int k);
		logic [15:0] sv, cw, op, ol;
		logic [2:0] xe;
		rnd(op);
		rnd(ol);
		rnd(x);
		sv = (k == 5) ? 16'h7FFC : (k > 5) ? 16'h7FFD : x & 16'h3FFF;
		rnd(x);
		cw = {x[15:9], sup, x[7:0]};
		wr(4'h2, op);
		wr(4'h3, ol);
		wr(4'h4, sv);
		wr(4'h5, cw);
		wr(4'h1, idx);
		// Both start bits once: the call must win
		wr(4'h0, (k == 3) ? 16'h0003 : 16'h0001);
		wr(4'h2, 16'hDEAD);
		waitend;
		chk({15'h0000, busy_r}, 16'h0000);
		chk(M.data[8'(sv + 16'h1)], op);
		chk(M.data[8'(sv + 16'h2)], cw);
		chk(M.data[8'(sv + 16'h3)], ol);
		xe = 3'b001;
		cp = op;
		cl = ol;
		cs = sv;
		cc = cw;
		if (!sup && idx >= C1)
			xe = 3'b010;
		else if ({1'b0, sv} + 17'h00003 > 17'h07FFF)
			xe = 3'b100;
		else begin
			cp = 16'h0100 + idx;
			cl = sv + 16'h0003;
			cs = cl;
			cc = {cw[15:9], cw[8] | (idx >= C0), cw[7:3], 3'h7};
		end
		chk({13'h0000, ev}, {13'h0000, xe});
		rdc(4'h6, {13'h0000, xe});
		rdc(4'h2, cp);
		rdc(4'h3, cl);
		rdc(4'h4, cs);
		rdc(4'h5, cc);
		if (xe == 3'b001)
			ret(op, cw, ol);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 8; a++)
			rdc(4'(a), (a == 5) ? 16'h0007 : 16'h0000);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			call(t_sup[k], {12'h000, t_idx[k*4 +: 4]}, k);
			$display("call test %0d done", k);
		end
		summarize;
	end
endmodule
